// File: rtl/gpc_pin_cell.v
`timescale 1ns/1ps
`include "gpc_regs.vh"

module gpc_pin_cell (
  input wire sys_clk_in,
  input wire rst_in,
  input wire wr_dir_in,
  input wire [1:0] dir_code_in,
  input wire wr_trig_in,
  input wire [2:0] trig_code_in,
  input wire wr_pad_in,
  input wire [1:0] drive_code_in,
  input wire [2:0] pad_code_in,
  input wire level_in,
  output wire [1:0] dir_out,
  output wire [2:0] trig_out,
  output wire [1:0] drive_out,
  output wire [2:0] pad_out,
  output reg hit_out
);

  reg [1:0] dir_ff;
  reg [2:0] trig_ff;
  reg [1:0] drive_ff;
  reg [2:0] pad_ff;
  reg level_ff;
  reg raw_hit;
  wire digital_on;

  // ----------------------------------------
  // Per-pin settings
  // ----------------------------------------
  // Pad is stored whole even on inputs; only the pulls and the analog type act there
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      dir_ff <= `GPC_DIR_RST;
      trig_ff <= `GPC_TRIG_RST;
      drive_ff <= `GPC_DRIVE_RST;
      pad_ff <= `GPC_PAD_RST;
    end else begin
      if (wr_dir_in) begin
        dir_ff <= dir_code_in;
      end
      if (wr_trig_in) begin
        trig_ff <= trig_code_in;
      end
      if (wr_pad_in) begin
        drive_ff <= drive_code_in;
        pad_ff <= pad_code_in;
      end
    end
  end

  // Previous level for edge detection; assumes a steady input while
  // the trigger type changes, otherwise a stray edge may be seen
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      level_ff <= 1'b0;
    end else begin
      level_ff <= level_in;
    end
  end

  assign digital_on = (pad_ff != `GPC_PAD_ANALOG);

  // ----------------------------------------
  // Trigger detector
  // ----------------------------------------
  // Raw hit kept apart so the output is never read back in this process
  always @* begin
    case (trig_ff)
      `GPC_TRIG_FALL: raw_hit = level_ff & ~level_in;
      `GPC_TRIG_RISE: raw_hit = ~level_ff & level_in;
      `GPC_TRIG_BOTH: raw_hit = level_ff ^ level_in;
      `GPC_TRIG_LOW: raw_hit = ~level_in;
      `GPC_TRIG_HIGH: raw_hit = level_in;
      default: raw_hit = 1'b0;
    endcase
    hit_out = raw_hit & digital_on;
  end

  assign dir_out = dir_ff;
  assign trig_out = trig_ff;
  assign drive_out = drive_ff;
  assign pad_out = pad_ff;

endmodule

// File: rtl/gpc_port.v
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`include "gpc_regs.vh"

// What this block does
// - Mask bit n selects pin n only
// - Direction: software input, software output, hardware
// - Direction of one pin reads back, same code
// - Five triggers: fall, rise, both, low, high
// - Trigger of one pin reads back, same code
// - Four drive settings, 2/4/8 mA, 8 slew
// - Seven pad types including analog
// - Input pins store pad fully; pull acts
// - Drive and pad of one pin read back
// - Reset: input, 2 mA, no pull, push-pull
// - At most eight pins, numbered 0-7

module gpc_port #(
  parameter NUM_PINS = 8
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire [7:0] pin_level_in,
  output wire [7:0] pin_oe_n_out,
  output wire [7:0] hardware_control_mode_out,
  output wire [15:0] drive_setting_out,
  output wire [7:0] open_drain_out,
  output wire [7:0] pullup_out,
  output wire [7:0] pulldown_out,
  output wire [7:0] analog_out,
  output wire irq_out
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [2:0] pin_index_ff;
  reg [7:0] int_status_ff;
  reg [7:0] int_mask_ff;
  reg [7:0] oe_n_ff;
  reg [7:0] hw_ff;
  reg [15:0] drive_ff;
  reg [7:0] od_ff;
  reg [7:0] pu_ff;
  reg [7:0] pd_ff;
  reg [7:0] analog_ff;
  reg [31:0] nxt_prdata;
  reg addr_ok;
  wire [7:0] pin_select_mask;
  wire [1:0] direction_setting;
  wire [2:0] trigger_type;
  wire [1:0] drive_setting;
  wire [2:0] pad_type;
  wire wr_en;
  wire rd_setup;
  wire dir_valid;
  wire trig_valid;
  wire pad_valid;
  wire wr_dir;
  wire wr_trig;
  wire wr_pad;
  wire [7:0] live_mask;
  wire [8:0] pin_span;
  wire [15:0] dir_all;
  wire [23:0] trig_all;
  wire [15:0] drv_all;
  wire [23:0] pad_all;
  wire [7:0] hit_all;
  wire [7:0] clr_bits;
  wire [7:0] digital_level;

  // ----------------------------------------
  // Write data fields
  // ----------------------------------------
  // Each configure write carries its own pin mask, so one transfer
  // updates every selected pin in the same cycle
  assign pin_select_mask = pwdata[`GPC_MASK_LSB +: 8];
  assign direction_setting = pwdata[`GPC_DIR_LSB +: 2];
  assign trigger_type = pwdata[`GPC_TRIG_LSB +: 3];
  assign drive_setting = pwdata[`GPC_DRIVE_LSB +: 2];
  assign pad_type = pwdata[`GPC_PAD_LSB +: 3];

  // Unused codes are refused whole, so no pin holds an undefined mode
  assign dir_valid = (direction_setting == `GPC_DIR_IN) |
                     (direction_setting == `GPC_DIR_OUT) |
                     (direction_setting == `GPC_DIR_HW);
  assign trig_valid = (trigger_type <= `GPC_TRIG_HIGH);
  assign pad_valid = (pad_type <= `GPC_PAD_ANALOG);

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Zero wait states: every access finishes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  // Address decode for the error answer
  always @* begin
    case (paddr)
      `GPC_DIR_SET_OFS: addr_ok = 1'b1;
      `GPC_TRIG_SET_OFS: addr_ok = 1'b1;
      `GPC_PAD_SET_OFS: addr_ok = 1'b1;
      `GPC_PIN_INDEX_OFS: addr_ok = 1'b1;
      `GPC_DIR_GET_OFS: addr_ok = 1'b1;
      `GPC_TRIG_GET_OFS: addr_ok = 1'b1;
      `GPC_PAD_GET_OFS: addr_ok = 1'b1;
      `GPC_INT_STATUS_OFS: addr_ok = 1'b1;
      `GPC_INT_MASK_OFS: addr_ok = 1'b1;
      `GPC_PIN_LEVEL_OFS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~addr_ok;

  // Configure strobes; pins beyond NUM_PINS never get one
  assign pin_span = (9'h100 >> (8 - NUM_PINS)) - 9'h001;
  assign live_mask = pin_select_mask & pin_span[7:0];
  assign wr_dir = wr_en & (paddr == `GPC_DIR_SET_OFS) & dir_valid;
  assign wr_trig = wr_en & (paddr == `GPC_TRIG_SET_OFS) & trig_valid;
  assign wr_pad = wr_en & (paddr == `GPC_PAD_SET_OFS) & pad_valid;

  // ----------------------------------------
  // Pin cells
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_pin
      gpc_pin_cell u_cell (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .wr_dir_in(wr_dir & live_mask[i]),
        .dir_code_in(direction_setting),
        .wr_trig_in(wr_trig & live_mask[i]),
        .trig_code_in(trigger_type),
        .wr_pad_in(wr_pad & live_mask[i]),
        .drive_code_in(drive_setting),
        .pad_code_in(pad_type),
        .level_in(pin_level_in[i]),
        .dir_out(dir_all[2*i +: 2]),
        .trig_out(trig_all[3*i +: 3]),
        .drive_out(drv_all[2*i +: 2]),
        .pad_out(pad_all[3*i +: 3]),
        .hit_out(hit_all[i])
      );
      // Analog pads have the digital input detached
      assign digital_level[i] = pin_level_in[i] &
                                (pad_all[3*i +: 3] != `GPC_PAD_ANALOG);
    end
  endgenerate

  // ----------------------------------------
  // Index and interrupt mask registers
  // ----------------------------------------
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      pin_index_ff <= `GPC_INDEX_RST;
      int_mask_ff <= `GPC_MASK_RST;
    end else if (wr_en) begin
      if (paddr == `GPC_PIN_INDEX_OFS) begin
        pin_index_ff <= pwdata[`GPC_INDEX_LSB +: 3];
      end
      if (paddr == `GPC_INT_MASK_OFS) begin
        int_mask_ff <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Interrupt status, write one to clear
  // ----------------------------------------
  // A trigger in the clearing cycle wins, so no event is dropped
  assign clr_bits = (wr_en & (paddr == `GPC_INT_STATUS_OFS)) ? pwdata[7:0] : 8'h00;

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      int_status_ff <= 8'h00;
    end else begin
      int_status_ff <= (int_status_ff & ~clr_bits) | (hit_all & live_pins(1'b1));
    end
  end

  // Pins present on this port instance
  function [7:0] live_pins;
    input dummy;
    integer k;
    begin
      live_pins = 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
        if (k < NUM_PINS) begin
          live_pins[k] = dummy;
        end
      end
    end
  endfunction

  assign irq_out = |(int_status_ff & int_mask_ff);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Captured in the setup cycle so prdata comes from a flip-flop
  always @* begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      `GPC_PIN_INDEX_OFS: nxt_prdata[2:0] = pin_index_ff;
      `GPC_DIR_GET_OFS: nxt_prdata[1:0] = dir_all[2*pin_index_ff +: 2];
      `GPC_TRIG_GET_OFS: nxt_prdata[2:0] = trig_all[3*pin_index_ff +: 3];
      `GPC_PAD_GET_OFS: begin
        nxt_prdata[`GPC_DRIVE_LSB +: 2] = drv_all[2*pin_index_ff +: 2];
        nxt_prdata[`GPC_PAD_LSB +: 3] = pad_all[3*pin_index_ff +: 3];
      end
      `GPC_INT_STATUS_OFS: nxt_prdata[7:0] = int_status_ff;
      `GPC_INT_MASK_OFS: nxt_prdata[7:0] = int_mask_ff;
      `GPC_PIN_LEVEL_OFS: nxt_prdata[7:0] = digital_level & live_pins(1'b1);
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= nxt_prdata;
    end
  end

  // ----------------------------------------
  // Pad control outputs
  // ----------------------------------------
  // Output enable acts on software outputs, open drain on software and hardware outputs; pulls act always,
  // which is why an input still honours its stored pull
  integer p;
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      oe_n_ff <= 8'hFF;
      hw_ff <= 8'h00;
      drive_ff <= 16'h0000;
      od_ff <= 8'h00;
      pu_ff <= 8'h00;
      pd_ff <= 8'h00;
      analog_ff <= 8'h00;
    end else begin
      for (p = 0; p < 8; p = p + 1) begin
        oe_n_ff[p] <= ~((dir_all[2*p +: 2] == `GPC_DIR_OUT) &
                        (pad_all[3*p +: 3] != `GPC_PAD_ANALOG));
        hw_ff[p] <= (dir_all[2*p +: 2] == `GPC_DIR_HW);
        drive_ff[2*p +: 2] <= drv_all[2*p +: 2];
        od_ff[p] <= (dir_all[2*p +: 2] != `GPC_DIR_IN) &
                    (pad_all[3*p +: 3] >= `GPC_PAD_OD) &
                    (pad_all[3*p +: 3] <= `GPC_PAD_OD_PD);
        pu_ff[p] <= (pad_all[3*p +: 3] == `GPC_PAD_PP_PU) |
                    (pad_all[3*p +: 3] == `GPC_PAD_OD_PU);
        pd_ff[p] <= (pad_all[3*p +: 3] == `GPC_PAD_PP_PD) |
                    (pad_all[3*p +: 3] == `GPC_PAD_OD_PD);
        analog_ff[p] <= (pad_all[3*p +: 3] == `GPC_PAD_ANALOG);
      end
    end
  end

  assign pin_oe_n_out = oe_n_ff;
  assign hardware_control_mode_out = hw_ff;
  assign drive_setting_out = drive_ff;
  assign open_drain_out = od_ff;
  assign pullup_out = pu_ff;
  assign pulldown_out = pd_ff;
  assign analog_out = analog_ff;

endmodule

// File: rtl/gpc_regs.vh
`ifndef GPC_REGS_VH
`define GPC_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define GPC_DIR_SET_OFS 8'h00
`define GPC_TRIG_SET_OFS 8'h04
`define GPC_PAD_SET_OFS 8'h08
`define GPC_PIN_INDEX_OFS 8'h0C
`define GPC_DIR_GET_OFS 8'h10
`define GPC_TRIG_GET_OFS 8'h14
`define GPC_PAD_GET_OFS 8'h18
`define GPC_INT_STATUS_OFS 8'h1C
`define GPC_INT_MASK_OFS 8'h20
`define GPC_PIN_LEVEL_OFS 8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GPC_MASK_LSB 0
`define GPC_DIR_LSB 8
`define GPC_TRIG_LSB 8
`define GPC_DRIVE_LSB 8
`define GPC_PAD_LSB 12
`define GPC_INDEX_LSB 0

// ----------------------------------------
// Direction settings
// ----------------------------------------
`define GPC_DIR_IN 2'h0
`define GPC_DIR_OUT 2'h1
`define GPC_DIR_HW 2'h2

// ----------------------------------------
// Trigger types
// ----------------------------------------
`define GPC_TRIG_FALL 3'h0
`define GPC_TRIG_RISE 3'h1
`define GPC_TRIG_BOTH 3'h2
`define GPC_TRIG_LOW 3'h3
`define GPC_TRIG_HIGH 3'h4

// ----------------------------------------
// Drive settings and pad types
// ----------------------------------------
`define GPC_DRIVE_WEAK 2'h0
`define GPC_DRIVE_MEDIUM 2'h1
`define GPC_DRIVE_STRONG 2'h2
`define GPC_DRIVE_STRONG_SLEW 2'h3
`define GPC_PAD_PP 3'h0
`define GPC_PAD_PP_PU 3'h1
`define GPC_PAD_PP_PD 3'h2
`define GPC_PAD_OD 3'h3
`define GPC_PAD_OD_PU 3'h4
`define GPC_PAD_OD_PD 3'h5
`define GPC_PAD_ANALOG 3'h6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GPC_DIR_RST 2'h0
`define GPC_TRIG_RST 3'h0
`define GPC_DRIVE_RST 2'h0
`define GPC_PAD_RST 3'h0
`define GPC_MASK_RST 8'h00
`define GPC_INDEX_RST 3'h0

`endif

// File: test/gpc_board.sv
`timescale 1ns/1ps

// ----------------------------------------
// Board pins
// ----------------------------------------
module gpc_board (
  input wire sys_clk_in,
  input wire [7:0] drive_en_in,
  input wire [7:0] drive_val_in,
  input wire [7:0] pullup_in,
  input wire [7:0] pulldown_in,
  output reg [7:0] pin_level_out
);
  initial pin_level_out = 8'h00;
  // Driven and pulled levels move only on command, so trigger changes see steady inputs
  // Released pins go to the pull, else flip, so stale values never match
  always @(posedge sys_clk_in) begin
    pin_level_out <= (drive_en_in & drive_val_in) | (~drive_en_in &
      (pullup_in | (~pulldown_in & ~pin_level_out)));
  end
endmodule

// File: test/gpc_port_assertions.sv
`timescale 1ns/1ps
`include "gpc_regs.vh"

// ----------------------------------------
// Port checker
// ----------------------------------------
module gpc_port_assertions #(
  parameter NUM_PINS = 8
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  input wire [7:0] pin_oe_n_out,
  input wire [7:0] hardware_control_mode_out,
  input wire [15:0] drive_setting_out,
  input wire irq_out
);
  // Decoded write strobes
  wire acc = psel & penable;
  wire dir_wr = acc & pwrite & (paddr == `GPC_DIR_SET_OFS);
  wire pad_wr = acc & pwrite & (paddr == `GPC_PAD_SET_OFS);
  wire mask_wr = acc & pwrite & (paddr == `GPC_INT_MASK_OFS);

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence hw_dir_s;
    dir_wr ##0 (pwdata[9:8] == `GPC_DIR_HW);
  endsequence
  // Pad outputs lag by a cycle, so two quiet cycles are needed
  sequence no_pad_s;
    !pad_wr ##1 !pad_wr;
  endsequence
  // Same lag on the hardware mode outputs; code 3 is refused
  sequence no_dir_s;
    (!dir_wr || pwdata[9:8] == 2'h3) ##1 (!dir_wr || pwdata[9:8] == 2'h3);
  endsequence

  zero_wait_a: assert property (acc |-> pready)
    else $error("pready low in access");
  err_access_a: assert property (pslverr |-> acc)
    else $error("pslverr outside access");
  mapped_ok_a: assert property (acc && paddr[1:0] == 2'h0 && paddr <= 8'h24 |-> !pslverr)
    else $error("pslverr on mapped address");
  reset_out_a: assert property (disable iff (1'b0) rst_in |=>
    pin_oe_n_out == 8'hFF && hardware_control_mode_out == 8'h00
    && drive_setting_out == 16'h0000 && !irq_out)
    else $error("outputs not at reset values");
  dir_select_a: assert property (hw_dir_s |-> ##2
    (hardware_control_mode_out & $past(pwdata[7:0], 2)) == $past(pwdata[7:0], 2)
    && ((hardware_control_mode_out ^ $past(hardware_control_mode_out))
    & ~$past(pwdata[7:0], 2)) == 8'h00)
    else $error("hardware mode mask wrong");
  dir_hold_a: assert property (no_dir_s |=>
    $stable(hardware_control_mode_out))
    else $error("hardware mode changed without write");
  pad_hold_a: assert property (no_pad_s |=> $stable(drive_setting_out))
    else $error("drive changed without write");
  drive_take_a: assert property (pad_wr && pwdata[0] && pwdata[14:12] != 3'h7 |->
    ##2 drive_setting_out[1:0] == $past(pwdata[9:8], 2))
    else $error("pin 0 drive not taken");
  mask_off_a: assert property (mask_wr && pwdata[7:0] == 8'h00 |=> !irq_out)
    else $error("irq with all masked");
  bad_read_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
endmodule

bind gpc_port gpc_port_assertions #(.NUM_PINS(NUM_PINS)) gpc_port_assertions_i (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .pin_oe_n_out(pin_oe_n_out),
  .hardware_control_mode_out(hardware_control_mode_out),
  .drive_setting_out(drive_setting_out), .irq_out(irq_out));

// File: test/gpc_port_test.sv
`timescale 1ns/1ps
`include "gpc_regs.vh"

module gpc_port_test;
  localparam [7:0] IX = `GPC_PIN_INDEX_OFS;
  localparam [7:0] IS = `GPC_INT_STATUS_OFS;
  localparam [7:0] MK = `GPC_INT_MASK_OFS;
  reg sys_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [7:0] b_en = 8'hFF;
  reg [7:0] b_val = 8'h00;
  reg [31:0] rd;
  reg slv;
  integer error_cnt = 0;
  integer num_checks = 0;
  integer i;
  integer d;
  integer p;
  wire pready, pslverr, irq_out;
  wire [31:0] prdata;
  wire [7:0] lvl, oe_n, hw, od, pu, pd, an;
  wire [15:0] drv;

  always #5 sys_clk_in = ~sys_clk_in;

  gpc_port gpc_port_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .pin_level_in(lvl),
    .pin_oe_n_out(oe_n), .hardware_control_mode_out(hw), .drive_setting_out(drv),
    .open_drain_out(od), .pullup_out(pu), .pulldown_out(pd), .analog_out(an),
    .irq_out(irq_out));
  gpc_board gpc_board_i (.sys_clk_in(sys_clk_in), .drive_en_in(b_en),
    .drive_val_in(b_val), .pullup_in(pu), .pulldown_in(pd), .pin_level_out(lvl));

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task tally_and_finish;
    begin
      if (error_cnt == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      num_checks++;
      if (seen !== exp) begin
        error_cnt++;
        $display("Error %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // One APB transfer; bounded wait on pready
  task apb(input w, input [7:0] a, input [31:0] dat);
    integer n;
    begin
      @(posedge sys_clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge sys_clk_in);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge sys_clk_in);
        n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
        error_cnt++;
        tally_and_finish;
      end
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Let registered outputs land before looking
  task settle;
    begin
      @(posedge sys_clk_in);
      #1;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    #1;
    chk("oe_n_rst", oe_n, 8'hFF);
    chk("drv_rst", drv, 16'h0);
    for (i = 0; i < 8; i++) begin
      apb(1, IX, i);
      apb(0, `GPC_DIR_GET_OFS, 0);
      chk("dir_rst", rd, `GPC_DIR_RST);
      apb(0, `GPC_TRIG_GET_OFS, 0);
      chk("trig_rst", rd, `GPC_TRIG_RST);
      apb(0, `GPC_PAD_GET_OFS, 0);
      chk("pad_rst", rd, 0);
    end
    // Direction per mask, invalid code dropped whole
    apb(1, `GPC_DIR_SET_OFS, {22'h0, `GPC_DIR_HW, 8'h09});
    apb(1, `GPC_DIR_SET_OFS, {22'h0, `GPC_DIR_OUT, 8'h02});
    apb(1, `GPC_DIR_SET_OFS, {22'h0, 2'h3, 8'hFF});
    settle;
    chk("hw_pins", hw, 8'h09);
    chk("oe_pins", oe_n, 8'hFD);
    for (i = 0; i < 4; i++) begin
      apb(1, IX, i);
      apb(0, `GPC_DIR_GET_OFS, 0);
      chk("dir_rb", rd, (i == 1) ? 1 : (i == 2) ? 0 : 2);
    end
    // Every trigger kind, one pin each
    for (i = 0; i < 5; i++)
      apb(1, `GPC_TRIG_SET_OFS, {21'h0, i[2:0], 8'h01 << i});
    apb(1, `GPC_TRIG_SET_OFS, {21'h0, 3'h5, 8'hFF});
    for (i = 0; i < 5; i++) begin
      apb(1, IX, i);
      apb(0, `GPC_TRIG_GET_OFS, 0);
      chk("trig_rb", rd, i);
    end
    // Every drive and pad on input pin 2
    apb(1, IX, 2);
    for (d = 0; d < 4; d++) begin
      for (p = 0; p < 7; p++) begin
        apb(1, `GPC_PAD_SET_OFS, {17'h0, p[2:0], 2'h0, d[1:0], 8'h04});
        apb(0, `GPC_PAD_GET_OFS, 0);
        chk("pad_rb", rd, {17'h0, p[2:0], 2'h0, d[1:0], 8'h00});
        chk("drv_pin", drv[5:4], d);
        chk("pad_pin", {an[2], od[2], pd[2], pu[2]},
          {p == 6, 1'b0, p == 2 || p == 5, p == 1 || p == 4});
      end
    end
    apb(1, `GPC_PAD_SET_OFS, {17'h0, 3'h7, 2'h0, 2'h1, 8'h04});
    apb(0, `GPC_PAD_GET_OFS, 0);
    chk("pad_bad", rd, {17'h0, 3'h6, 2'h0, 2'h3, 8'h00});
    // Rising edge on pin 5, then mask and clear
    apb(1, `GPC_TRIG_SET_OFS, {21'h0, `GPC_TRIG_RISE, 8'hFF});
    apb(1, IS, 32'hFF);
    apb(1, MK, 32'h0);
    settle;
    chk("irq_off", irq_out, 0);
    b_val <= 8'h20;
    repeat (3) @(posedge sys_clk_in);
    apb(0, IS, 0);
    chk("status", rd, 32'h20);
    apb(0, `GPC_PIN_LEVEL_OFS, 0);
    chk("level", rd, 32'h20);
    chk("irq_mask", irq_out, 0);
    apb(1, MK, 32'h20);
    settle;
    chk("irq_on", irq_out, 1);
    apb(0, MK, 0);
    chk("mask_rb", rd, 32'h20);
    apb(1, IS, 32'h20);
    settle;
    chk("irq_clr", irq_out, 0);
    apb(0, IS, 0);
    chk("status_clr", rd, 32'h0);
    // Unmapped place refuses
    apb(0, 8'h40, 0);
    chk("slverr", slv, 1);
    chk("rd_err", rd, 32'h0);
    // Level trigger refires over a clear; falling edge on pin 5
    apb(1, `GPC_TRIG_SET_OFS, {21'h0, `GPC_TRIG_HIGH, 8'h20});
    apb(1, IS, 32'h20);
    apb(0, IS, 0);
    chk("lvl_hold", rd, 32'h20);
    apb(1, `GPC_TRIG_SET_OFS, {21'h0, `GPC_TRIG_FALL, 8'h20});
    apb(1, IS, 32'h20);
    apb(0, IS, 0);
    chk("fall_idle", rd, 32'h0);
    b_val <= 8'h00;
    repeat (3) @(posedge sys_clk_in);
    apb(0, IS, 0);
    chk("fall_hit", rd, 32'h20);
    // Open drain only on the output pin; pulls act on the input pin
    apb(1, `GPC_PAD_SET_OFS, {17'h0, `GPC_PAD_OD_PU, 2'h0, 2'h0, 8'h06});
    settle;
    chk("od_pins", od[2:1], 2'b01);
    chk("pu_pins", pu[2:1], 2'b11);
    b_en <= 8'hFB;
    apb(0, `GPC_PIN_LEVEL_OFS, 0);
    chk("pull_up", rd, 32'h04);
    apb(1, `GPC_PAD_SET_OFS, {17'h0, `GPC_PAD_OD_PD, 2'h0, 2'h0, 8'h04});
    settle;
    apb(0, `GPC_PIN_LEVEL_OFS, 0);
    chk("pull_down", rd, 32'h00);
    // Reset in mid-run brings every pin back to its default
    rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    #1;
    chk("hw_rst", hw, 8'h00);
    chk("od_rst", od, 8'h00);
    chk("oe_n_rst2", oe_n, 8'hFF);
    tally_and_finish;
  end
endmodule
